// ==== logic/capture_channel.v ====
// one input capture channel with mode decode, capture buffer and
// the second control register, behind an AXI4-Lite register slave.
// assumes all inputs are synchronous to clk_sys_in.
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "capture_map.vh"

// What this block does
// R1: mode 111 only flags rising edges as interrupt while sleeping or idle.
// R2: mode 110 disables the channel; no captures happen.
// R3: mode 101 captures every 16th rising edge, 100 every 4th.
// R4: mode 011 captures each rising edge, 010 each falling edge.
// R5: mode 001 captures on every edge, rising and falling.
// R6: buffer status reads 1 while a captured value remains, else 0.
// R7: the input comes from a remappable pin chosen by pin selection.
// R8: cascade bit at 8, read/write, reset 0; bits 15-9 read zero.
// R9: trigger status bit 6 read/write, reset 0, hardware settable; bit 5 zero.
// R10: trigger/sync select at bit 7, read/write, reset 0.
// R11: sync source bits 4-0, read/write, reset 01101.
// R12: hardware sets trigger status on source event while running; clear holds timer.
// R13: select 1 triggers from chosen source, 0 synchronises to it.
// R14: cascade in both paired channels makes one 32-bit unit.
// R15: codes 10100-10111 pick the other capture channels; reserved pick nothing.
// R16: mode 000 turns the channel off and clears its prescaler.
module capture_channel
(
    // clock and reset
    input  wire        clk_sys_in,
    input  wire        arst_n_in,
    // pins and system events
    input  wire [7:0]  remappable_pin_in,
    input  wire [2:0]  pin_select_in,
    input  wire        sleep_idle_in,
    input  wire [31:0] sync_events_in,
    input  wire        partner_cascade_in,
    input  wire [15:0] timebase_in,
    // timebase control and interrupt
    output reg         timer_hold_out,
    output reg         timer_sync_out,
    output reg         cascade_active_out,
    output reg         irq_out,
    // axi4-lite write address
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

    reg  [2:0]  capture_mode_sel_reg;
    reg  [15:0] ctrl_two_reg;
    reg  [2:0]  irq_status_reg;
    reg  [2:0]  irq_mask_reg;
    reg         pin_prev_reg;
    reg  [3:0]  prescale_reg;
    reg  [15:0] buf_mem [0:`BUF_DEPTH-1];
    reg  [1:0]  wr_ptr_reg;
    reg  [1:0]  rd_ptr_reg;
    reg  [2:0]  count_reg;
    reg         overflow_reg;
    reg  [3:0]  aw_addr_reg;
    reg         aw_have_reg;
    reg  [31:0] w_data_reg;
    reg  [3:0]  w_strb_reg;
    reg         w_have_reg;
    reg  [15:0] ctrl_two_next;
    reg  [2:0]  irq_status_next;
    reg         capture_event;
    reg  [31:0] rdata_next;
    reg         read_pops;

    wire        cascade_wide_enable  = ctrl_two_reg[`BIT_CASCADE];
    wire        trigger_or_sync_sel  = ctrl_two_reg[`BIT_TRIG_SEL];
    wire        trigger_status_flag  = ctrl_two_reg[`BIT_TRIG_STAT];
    wire [4:0]  sync_source_sel      = ctrl_two_reg[4:0];
    wire        capture_input = remappable_pin_in[pin_select_in]; // R7
    wire        rise = capture_input & ~pin_prev_reg;
    wire        fall = ~capture_input & pin_prev_reg;
    wire        buffer_not_empty_flag = (count_reg != 3'h0); // R6
    wire        buf_full = (count_reg == `BUF_DEPTH);
    wire        src_reserved = (sync_source_sel >= 5'h1D) ||
                               (sync_source_sel >= 5'h10 &&
                                sync_source_sel <= 5'h13) ||
                               (sync_source_sel >= 5'h07 &&
                                sync_source_sel <= 5'h09);
    // reserved codes select nothing; capture codes are ordinary inputs
    wire        src_event = src_reserved ? 1'b0 :
                            sync_events_in[sync_source_sel]; // R15
    wire        aw_go = aw_have_reg & w_have_reg & ~s_axi_bvalid;
    wire        ar_go = s_axi_arvalid & s_axi_arready;

    // mode decode and prescaler
    always @*
    begin
        capture_event = 1'b0;
        case (capture_mode_sel_reg)
            `MODE_BOTH:  capture_event = rise | fall;              // R5
            `MODE_FALL:  capture_event = fall;                     // R4
            `MODE_RISE:  capture_event = rise;                     // R4
            `MODE_DIV4:  capture_event = rise & (prescale_reg[1:0] == 2'h3); // R3
            `MODE_DIV16: capture_event = rise & (prescale_reg == 4'hF); // R3
            `MODE_DISABLED: capture_event = 1'b0;                  // R2
            `MODE_WAKE:  capture_event = 1'b0;                     // R1
            default:     capture_event = 1'b0;                     // R16
        endcase
    end

    always @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            pin_prev_reg <= 1'b0;
            prescale_reg <= 4'h0;
        end
        else
        begin
            pin_prev_reg <= capture_input;
            if (capture_mode_sel_reg == `MODE_OFF)
                prescale_reg <= 4'h0;                              // R16
            else if (rise && (capture_mode_sel_reg == `MODE_DIV4 ||
                              capture_mode_sel_reg == `MODE_DIV16))
                prescale_reg <= prescale_reg + 4'h1;               // R3
        end
    end

    // capture buffer; a full buffer drops new captures and flags overflow
    always @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            wr_ptr_reg   <= 2'h0;
            rd_ptr_reg   <= 2'h0;
            count_reg    <= 3'h0;
            overflow_reg <= 1'b0;
        end
        else
        begin
            if (capture_mode_sel_reg == `MODE_OFF)
            begin
                wr_ptr_reg   <= 2'h0;
                rd_ptr_reg   <= 2'h0;
                count_reg    <= 3'h0;
                overflow_reg <= 1'b0;
            end
            else
            begin
                if (capture_event && !buf_full)
                    wr_ptr_reg <= wr_ptr_reg + 2'h1;
                if (capture_event && buf_full)
                    overflow_reg <= 1'b1;
                if (read_pops)
                    rd_ptr_reg <= rd_ptr_reg + 2'h1;
                count_reg <= count_reg
                    + {2'h0, capture_event & ~buf_full}
                    - {2'h0, read_pops};                           // R6
            end
        end
    end

    always @(posedge clk_sys_in)
    begin
        if (capture_event && !buf_full)
            buf_mem[wr_ptr_reg] <= timebase_in;
    end

    // second control register and interrupt status, set wins over clear
    always @*
    begin
        ctrl_two_next   = ctrl_two_reg;
        irq_status_next = irq_status_reg;
        if (aw_go && aw_addr_reg == `OFS_CTRL_TWO)
        begin
            if (w_strb_reg[0])
                ctrl_two_next[7:0] = w_data_reg[7:0];
            if (w_strb_reg[1])
                ctrl_two_next[15:8] = w_data_reg[15:8];
            ctrl_two_next = ctrl_two_next & `CTRL_TWO_WMASK;       // R8
        end
        if (aw_go && aw_addr_reg == `OFS_IRQ_STATUS && w_strb_reg[0])
            irq_status_next = irq_status_reg & ~w_data_reg[2:0];
        if (src_event && trigger_or_sync_sel &&
            capture_mode_sel_reg != `MODE_WAKE)
            ctrl_two_next[`BIT_TRIG_STAT] = 1'b1;                  // R9 R12
        if (capture_event)
            irq_status_next[`IRQ_CAPTURE] = 1'b1;
        if (src_event && trigger_or_sync_sel && !trigger_status_flag)
            irq_status_next[`IRQ_TRIGGER] = 1'b1;
        if (capture_mode_sel_reg == `MODE_WAKE && sleep_idle_in && rise)
            irq_status_next[`IRQ_WAKE] = 1'b1;                     // R1
    end

    always @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            ctrl_two_reg         <= `CTRL_TWO_RESET;               // R11
            irq_status_reg       <= 3'h0;
            irq_mask_reg         <= 3'h0;
            capture_mode_sel_reg <= `MODE_OFF;
            timer_hold_out       <= 1'b1;
            timer_sync_out       <= 1'b0;
            cascade_active_out   <= 1'b0;
            irq_out              <= 1'b0;
        end
        else
        begin
            ctrl_two_reg   <= ctrl_two_next;                       // R10
            irq_status_reg <= irq_status_next;
            if (aw_go && aw_addr_reg == `OFS_CTRL_ONE)
            begin
                if (w_strb_reg[0])
                    capture_mode_sel_reg <= w_data_reg[2:0];
                if (w_strb_reg[1])
                    irq_mask_reg <= w_data_reg[10:8];
            end
            // trigger mode holds timer while status clear; wake ignores
            timer_hold_out <= trigger_or_sync_sel &
                              ~ctrl_two_next[`BIT_TRIG_STAT] &
                              (capture_mode_sel_reg != `MODE_WAKE); // R12
            timer_sync_out <= ~trigger_or_sync_sel & src_event &
                              (capture_mode_sel_reg != `MODE_WAKE); // R13
            cascade_active_out <= cascade_wide_enable &
                                  partner_cascade_in;              // R14
            irq_out <= |(irq_status_next & irq_mask_reg);
        end
    end

    // axi4-lite slave; address and data accepted in either order
    always @*
    begin
        rdata_next = 32'h0000_0000;
        read_pops  = 1'b0;
        case (s_axi_araddr)
            `OFS_CTRL_ONE:
                rdata_next = {21'h0, irq_mask_reg, 3'h0, overflow_reg,
                              buffer_not_empty_flag, capture_mode_sel_reg};
            `OFS_CTRL_TWO:
                rdata_next = {16'h0, ctrl_two_reg};                // R9
            `OFS_CAPTURE_DATA:
            begin
                rdata_next = {16'h0, buf_mem[rd_ptr_reg]};
                read_pops  = ar_go & buffer_not_empty_flag;
            end
            `OFS_IRQ_STATUS:
                rdata_next = {29'h0, irq_status_reg};
            default:
                rdata_next = 32'h0000_0000;
        endcase
    end

    always @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= 2'h0;
            s_axi_rdata   <= 32'h0000_0000;
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            aw_addr_reg   <= 4'h0;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 4'h0;
        end
        else
        begin
            s_axi_awready <= ~aw_have_reg & ~s_axi_awready & ~aw_go;
            s_axi_wready  <= ~w_have_reg & ~s_axi_wready & ~aw_go;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_reg   <= 1'b1;
                aw_addr_reg   <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_reg   <= 1'b1;
                w_data_reg   <= s_axi_wdata;
                w_strb_reg   <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (aw_go)
            begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_reg == `OFS_CAPTURE_DATA) ?
                                2'h0 : 2'h0;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid &
                             s_axi_arvalid;
            if (ar_go)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rdata_next;
                s_axi_rresp  <= 2'h0;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ==== logic/capture_map.vh ====
// register offsets, field positions, reset values and codes for the
// input capture channel; included by the capture channel design file
`ifndef CAPTURE_MAP_VH
`define CAPTURE_MAP_VH

`define OFS_CTRL_ONE      4'h0
`define OFS_CTRL_TWO      4'h4
`define OFS_CAPTURE_DATA  4'h8
`define OFS_IRQ_STATUS    4'hC

`define CTRL_TWO_RESET    16'h000D
`define CTRL_TWO_WMASK    16'h01DF
`define BIT_CASCADE       8
`define BIT_TRIG_SEL      7
`define BIT_TRIG_STAT     6

`define MODE_OFF          3'h0
`define MODE_BOTH         3'h1
`define MODE_FALL         3'h2
`define MODE_RISE         3'h3
`define MODE_DIV4         3'h4
`define MODE_DIV16        3'h5
`define MODE_DISABLED     3'h6
`define MODE_WAKE         3'h7

`define SRC_CAP_FIRST     5'h14
`define SRC_CAP_LAST      5'h17

`define IRQ_CAPTURE       0
`define IRQ_TRIGGER       1
`define IRQ_WAKE          2
`define IRQ_MASK_OFS      4'h0

`define BUF_DEPTH         4
`endif

// ==== verification/capture_props.sv ====
// port assertions for the capture channel, bound to every instance
// assumes one clock domain and the active-low asynchronous reset
`timescale 1ns/1ps
module capture_props
(
    // clock and reset
    input wire        clk_sys_in,
    input wire        arst_n_in,
    // system side
    input wire [31:0] sync_events_in,
    input wire        partner_cascade_in,
    input wire        timer_sync_out,
    input wire        cascade_active_out,
    // register bus
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!arst_n_in);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_WR_ANSWER: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    AST_RD_ANSWER: assert property (s_rd_taken |-> ##[1:2] s_axi_rvalid)
        else $error("read data late");
    AST_B_STANDS: assert property
        (s_axi_bvalid |=> s_axi_bvalid != $past(s_axi_bready))
        else $error("write response not held or not released");
    AST_R_STANDS: assert property
        (s_axi_rvalid |=> s_axi_rvalid != $past(s_axi_rready))
        else $error("read data not held or not released");
    AST_BRESP_OKAY: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
        else $error("write response not okay");
    AST_RRESP_OKAY: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0)
        else $error("read response not okay");
    AST_CASCADE_PAIR: assert property
        (cascade_active_out |-> $past(partner_cascade_in))
        else $error("cascade without partner bit");
    AST_SYNC_SOURCE: assert property
        (timer_sync_out |-> ($past(sync_events_in) != 32'h0
            || $past(sync_events_in, 2) != 32'h0))
        else $error("sync pulse without source event");
endmodule

bind capture_channel capture_props i_props
(
    .clk_sys_in, .arst_n_in, .sync_events_in, .partner_cascade_in,
    .timer_sync_out, .cascade_active_out, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
);

// ==== verification/pin_source.sv ====
// far side of the capture input: drives the candidate pins
// assumes the bench sets the level of the selected pin
`timescale 1ns/1ps
module pin_source
(
    // clock and control
    input  wire       clk_sys_in,
    input  wire [2:0] sel_in,
    input  wire       level_in,
    // pins
    output reg  [7:0] pins_out
);
    reg junk_reg = 1'h0;
    always @(posedge clk_sys_in)
    begin
        junk_reg <= ~junk_reg;
    end
    // unrouted pins toggle so a wrong selection shows as extra edges
    always @*
    begin
        pins_out = {8{junk_reg}};
        pins_out[sel_in] = level_in;
    end
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the capture channel
// assumes the design header and the bound checker are compiled first
`timescale 1ns/1ps
`include "capture_map.vh"
`define CHK(g, e) check_val(g, e)
module tb_top;
    reg         clk_sys_in = 1'h0;
    reg         arst_n_in = 1'h0;
    reg  [2:0]  pin_select_in = 3'h5;
    reg         sleep_idle_in = 1'h0;
    reg  [31:0] sync_events_in = 32'h0;
    reg         partner_cascade_in = 1'h0;
    reg  [15:0] timebase_in = 16'h0;
    reg  [3:0]  s_axi_awaddr = 4'h0;
    reg  [3:0]  s_axi_araddr = 4'h0;
    reg  [31:0] s_axi_wdata = 32'h0;
    reg  [3:0]  s_axi_wstrb = 4'hF;
    reg         s_axi_awvalid = 1'h0;
    reg         s_axi_wvalid = 1'h0;
    reg         s_axi_bready = 1'h0;
    reg         s_axi_arvalid = 1'h0;
    reg         s_axi_rready = 1'h0;
    reg         pin_level = 1'h0;
    wire [7:0]  remappable_pin_in;
    wire        timer_hold_out, timer_sync_out, cascade_active_out, irq_out;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire        s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    integer     error_cnt = 0;
    integer     checks_done = 0;
    integer     np [0:6] = '{2, 2, 2, 2, 7, 31, 2};
    integer     ex [0:6] = '{0, 4, 2, 2, 1, 1, 0};

    always #5 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) timebase_in <= timebase_in + 16'h1;

    pin_source i_pins (.clk_sys_in, .sel_in(pin_select_in),
        .level_in(pin_level), .pins_out(remappable_pin_in));
    capture_channel i_dut (.clk_sys_in, .arst_n_in, .remappable_pin_in,
        .pin_select_in, .sleep_idle_in, .sync_events_in, .partner_cascade_in,
        .timebase_in, .timer_hold_out, .timer_sync_out, .cascade_active_out,
        .irq_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    task complete_run;
        begin
            $display("Errors %0d of %0d checks", error_cnt, checks_done);
            if (error_cnt == 0 && checks_done > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    task check_val(input logic [31:0] g, input logic [31:0] e);
        begin
            #1;
            checks_done = checks_done + 1;
            if (g !== e)
            begin
                error_cnt = error_cnt + 1;
                $display("Error at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask

    task hang(input integer n);
        begin
            if (n >= 50)
            begin
                error_cnt = error_cnt + 1;
                $display("Error at %0t: got %h expected %h", $time, 0, 1);
                complete_run;
            end
        end
    endtask

    task automatic wr(input [3:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge clk_sys_in);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'h1;
            s_axi_wvalid <= 1'h1;
            s_axi_bready <= 1'h1;
            n = 0;
            do
            begin
                @(posedge clk_sys_in);
                if (s_axi_awready) s_axi_awvalid <= 1'h0;
                if (s_axi_wready) s_axi_wvalid <= 1'h0;
                n = n + 1;
            end
            while (((s_axi_awvalid && !s_axi_awready)
                || (s_axi_wvalid && !s_axi_wready)) && n < 50);
            while (s_axi_bvalid !== 1'h1 && n < 50)
            begin
                @(posedge clk_sys_in);
                n = n + 1;
            end
            s_axi_bready <= 1'h0;
            hang(n);
        end
    endtask

    task automatic rd(input [3:0] a, output [31:0] d);
        integer n;
        begin
            @(posedge clk_sys_in);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'h1;
            s_axi_rready <= 1'h1;
            n = 0;
            do
            begin
                @(posedge clk_sys_in);
                n = n + 1;
            end
            while (s_axi_arready !== 1'h1 && n < 50);
            s_axi_arvalid <= 1'h0;
            while (s_axi_rvalid !== 1'h1 && n < 50)
            begin
                @(posedge clk_sys_in);
                n = n + 1;
            end
            d = s_axi_rdata;
            s_axi_rready <= 1'h0;
            hang(n);
        end
    endtask

    task automatic pulses(input integer k);
        repeat (2 * k)
        begin
            @(posedge clk_sys_in);
            pin_level <= ~pin_level;
            repeat (2) @(posedge clk_sys_in);
        end
    endtask

    // pops the buffer while its status says a value is left
    task automatic drain(output integer c);
        reg [31:0] v;
        integer i;
        begin
            c = 0;
            for (i = 0; i < 6; i = i + 1)
            begin
                rd(`OFS_CTRL_ONE, v);
                if (v[3])
                begin
                    rd(`OFS_CAPTURE_DATA, v);
                    c = c + 1;
                end
            end
        end
    endtask

    task automatic fire(input integer k, output reg seen);
        integer i;
        begin
            seen = 1'h0;
            @(posedge clk_sys_in);
            sync_events_in <= 32'h1 << k;
            @(posedge clk_sys_in);
            sync_events_in <= 32'h0;
            for (i = 0; i < 4; i = i + 1)
            begin
                @(posedge clk_sys_in);
                if (timer_sync_out === 1'h1) seen = 1'h1;
            end
        end
    endtask

    task automatic t_regs;
        reg [31:0] v;
        begin
            rd(`OFS_CTRL_TWO, v);
            `CHK(v, 32'h000D);
            wr(`OFS_CTRL_TWO, 32'hFFFFFFFF);
            rd(`OFS_CTRL_TWO, v);
            `CHK(v, 32'h01DF);
            @(posedge clk_sys_in);
            partner_cascade_in <= 1'h1;
            repeat (3) @(posedge clk_sys_in);
            `CHK(cascade_active_out, 1'h1);
            wr(`OFS_CTRL_TWO, 32'h000D);
            repeat (2) @(posedge clk_sys_in);
            `CHK(cascade_active_out, 1'h0);
            @(posedge clk_sys_in);
            partner_cascade_in <= 1'h0;
        end
    endtask

    task automatic t_modes;
        integer m, c;
        for (m = 0; m < 7; m = m + 1)
        begin
            wr(`OFS_CTRL_ONE, 32'h0);
            wr(`OFS_CTRL_ONE, m);
            pulses(np[m]);
            drain(c);
            `CHK(c, ex[m]);
        end
    endtask

    task automatic t_wake;
        reg [31:0] v;
        integer c;
        begin
            // earlier captures left status set; clear it so only wake counts
            wr(`OFS_IRQ_STATUS, 32'h7);
            wr(`OFS_CTRL_ONE, 32'h0407);
            pulses(1);
            rd(`OFS_IRQ_STATUS, v);
            `CHK(v[2], 1'h0);
            @(posedge clk_sys_in);
            sleep_idle_in <= 1'h1;
            pulses(1);
            `CHK(irq_out, 1'h1);
            drain(c);
            `CHK(c, 0);
            wr(`OFS_IRQ_STATUS, 32'h4);
            repeat (2) @(posedge clk_sys_in);
            `CHK(irq_out, 1'h0);
            wr(`OFS_CTRL_ONE, 32'h0307);
            pulses(1);
            `CHK(irq_out, 1'h0);
            rd(`OFS_IRQ_STATUS, v);
            `CHK(v[2], 1'h1);
            @(posedge clk_sys_in);
            sleep_idle_in <= 1'h0;
        end
    endtask

    task automatic t_sync;
        reg [31:0] v;
        reg s;
        begin
            // wake mode ignores the sync controls except for the trigger interrupt, so leave it first
            wr(`OFS_CTRL_ONE, 32'h0);
            wr(`OFS_CTRL_TWO, 32'h0014);
            fire(20, s);
            `CHK(s, 1'h1);
            wr(`OFS_CTRL_TWO, 32'h001F);
            fire(31, s);
            `CHK(s, 1'h0);
            wr(`OFS_CTRL_TWO, 32'h0094);
            fire(21, s);
            `CHK(timer_hold_out, 1'h1);
            fire(20, s);
            `CHK(timer_hold_out, 1'h0);
            rd(`OFS_CTRL_TWO, v);
            `CHK(v, 32'h00D4);
            wr(`OFS_CTRL_TWO, 32'h0094);
            repeat (2) @(posedge clk_sys_in);
            `CHK(timer_hold_out, 1'h1);
            wr(`OFS_CTRL_TWO, 32'h00D4);
            repeat (2) @(posedge clk_sys_in);
            `CHK(timer_hold_out, 1'h0);
        end
    endtask

    initial
    begin
        repeat (20) @(posedge clk_sys_in);
        arst_n_in <= 1'h1;
        t_regs;
        t_modes;
        t_wake;
        t_sync;
        complete_run;
    end
endmodule
